/* rtl/sfr_bank_pkg.sv */
// Package: special register space offsets, reset values and carriers
package sfr_bank_pkg;

    localparam logic [7:0] OFF_PORT0       = 8'h80;
    localparam logic [7:0] OFF_SP          = 8'h81;
    localparam logic [7:0] OFF_PTR0_LOW    = 8'h82;
    localparam logic [7:0] OFF_PTR0_HIGH   = 8'h83;
    localparam logic [7:0] OFF_PTR1_LOW    = 8'h84;
    localparam logic [7:0] OFF_PTR1_HIGH   = 8'h85;
    localparam logic [7:0] OFF_POWER       = 8'h87;
    localparam logic [7:0] OFF_CNT_CTRL    = 8'h88;
    localparam logic [7:0] OFF_CNT_MODE    = 8'h89;
    localparam logic [7:0] OFF_CNT0_LOW    = 8'h8A;
    localparam logic [7:0] OFF_CNT1_LOW    = 8'h8B;
    localparam logic [7:0] OFF_CNT0_HIGH   = 8'h8C;
    localparam logic [7:0] OFF_CNT1_HIGH   = 8'h8D;
    localparam logic [7:0] OFF_STRETCH     = 8'h8E;
    localparam logic [7:0] OFF_PTR_SELECT  = 8'h92;
    localparam logic [7:0] OFF_SER0_CTRL   = 8'h98;
    localparam logic [7:0] OFF_SER0_BUF    = 8'h99;
    localparam logic [7:0] OFF_IRQ_EN2     = 8'h9A;
    localparam logic [7:0] OFF_SER1_CTRL   = 8'h9B;
    localparam logic [7:0] OFF_SER1_BUF    = 8'h9C;
    localparam logic [7:0] OFF_SER1_RELL   = 8'h9D;
    localparam logic [7:0] OFF_IRQ_EN0     = 8'hA8;
    localparam logic [7:0] OFF_IRQ_PRI0    = 8'hA9;
    localparam logic [7:0] OFF_SER0_RELL   = 8'hAA;
    localparam logic [7:0] OFF_IRQ_EN1     = 8'hB8;
    localparam logic [7:0] OFF_IRQ_PRI1    = 8'hB9;
    localparam logic [7:0] OFF_SER0_RELH   = 8'hBA;
    localparam logic [7:0] OFF_SER1_RELH   = 8'hBB;
    localparam logic [7:0] OFF_PAGED_HIGH  = 8'hBF;
    localparam logic [7:0] OFF_IRQ_REQ     = 8'hC0;
    localparam logic [7:0] OFF_EXT_POL     = 8'hC8;
    localparam logic [7:0] OFF_PSW         = 8'hD0;
    localparam logic [7:0] OFF_BAUD_CTRL   = 8'hD8;
    localparam logic [7:0] OFF_ACC         = 8'hE0;
    localparam logic [7:0] OFF_MUL_AUX     = 8'hF0;

    localparam int          NUM_REGS       = 35;
    localparam logic [7:0]  RST_PORT0      = 8'hFF;
    localparam logic [7:0]  RST_SP         = 8'h07;
    localparam logic [7:0]  RST_STRETCH    = 8'h01;
    localparam logic [7:0]  RST_SER0_RELL  = 8'hD9;
    localparam logic [7:0]  RST_RELH       = 8'h03;
    localparam logic [7:0]  RST_ZERO       = 8'h00;
    localparam logic [7:0]  BAUD_CTRL_MASK = 8'h80;

    localparam int PSW_CARRY  = 7;
    localparam int PSW_AUX    = 6;
    localparam int PSW_USER0  = 5;
    localparam int PSW_BANK_H = 4;
    localparam int PSW_BANK_L = 3;
    localparam int PSW_OVF    = 2;
    localparam int PSW_USER1  = 1;
    localparam int PSW_PARITY = 0;

    // Access kinds of the core's direct-address port
    typedef enum logic [1:0] {ACC_NONE, ACC_BYTE, ACC_BIT} access_e;

    // One direct-address request from the core
    typedef struct packed {
        access_e    kind;
        logic       write;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } sfr_req_s;

    // Core-side ALU flag update for the status word
    typedef struct packed {
        logic carry_we;
        logic carry;
        logic aux_we;
        logic aux;
        logic ovf_we;
        logic ovf;
    } flag_upd_s;

endpackage

/* rtl/special_register_space.sv */
// Special register space: generic core registers, direct-address port
`timescale 1ns/1ps
module special_register_space
(
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire sfr_bank_pkg::sfr_req_s  req,
    input  wire logic                    indirect,
    input  wire sfr_bank_pkg::flag_upd_s flag_upd,
    input  wire logic                    stack_push,
    input  wire logic                    acc_we,
    input  wire logic [7:0]              acc_wdata,
    output logic [7:0]                   rdata_ff,
    output logic                         rbit_ff,
    output logic                         hit_ff,
    output logic [4:0]                   bank_base_ff,
    output logic [15:0]                  data_pointer_ff,
    output logic [7:0]                   paged_address_high_ff,
    output logic [7:0]                   stack_pointer_ff,
    output logic [7:0]                   accumulator_ff,
    output logic [7:0]                   program_status_word_ff
);

    localparam int N = sfr_bank_pkg::NUM_REGS;

    typedef logic [7:0] byte_t;

    // Implemented offsets and reset values, same order
    localparam byte_t OFFS [N] = '{
        sfr_bank_pkg::OFF_PORT0,     sfr_bank_pkg::OFF_SP,
        sfr_bank_pkg::OFF_PTR0_LOW,  sfr_bank_pkg::OFF_PTR0_HIGH,
        sfr_bank_pkg::OFF_PTR1_LOW,  sfr_bank_pkg::OFF_PTR1_HIGH,
        sfr_bank_pkg::OFF_POWER,     sfr_bank_pkg::OFF_CNT_CTRL,
        sfr_bank_pkg::OFF_CNT_MODE,  sfr_bank_pkg::OFF_CNT0_LOW,
        sfr_bank_pkg::OFF_CNT1_LOW,  sfr_bank_pkg::OFF_CNT0_HIGH,
        sfr_bank_pkg::OFF_CNT1_HIGH, sfr_bank_pkg::OFF_STRETCH,
        sfr_bank_pkg::OFF_PTR_SELECT, sfr_bank_pkg::OFF_SER0_CTRL,
        sfr_bank_pkg::OFF_SER0_BUF,  sfr_bank_pkg::OFF_IRQ_EN2,
        sfr_bank_pkg::OFF_SER1_CTRL, sfr_bank_pkg::OFF_SER1_BUF,
        sfr_bank_pkg::OFF_SER1_RELL, sfr_bank_pkg::OFF_IRQ_EN0,
        sfr_bank_pkg::OFF_IRQ_PRI0,  sfr_bank_pkg::OFF_SER0_RELL,
        sfr_bank_pkg::OFF_IRQ_EN1,   sfr_bank_pkg::OFF_IRQ_PRI1,
        sfr_bank_pkg::OFF_SER0_RELH, sfr_bank_pkg::OFF_SER1_RELH,
        sfr_bank_pkg::OFF_PAGED_HIGH, sfr_bank_pkg::OFF_IRQ_REQ,
        sfr_bank_pkg::OFF_EXT_POL,   sfr_bank_pkg::OFF_PSW,
        sfr_bank_pkg::OFF_BAUD_CTRL, sfr_bank_pkg::OFF_ACC,
        sfr_bank_pkg::OFF_MUL_AUX
    };

    localparam byte_t RSTS [N] = '{
        sfr_bank_pkg::RST_PORT0,     sfr_bank_pkg::RST_SP,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_STRETCH,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_SER0_RELL,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_RELH,      sfr_bank_pkg::RST_RELH,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO,      sfr_bank_pkg::RST_ZERO,
        sfr_bank_pkg::RST_ZERO
    };

    // Register indices used by dedicated logic
    localparam int IX_SP   = 1;
    localparam int IX_D0L  = 2;
    localparam int IX_D0H  = 3;
    localparam int IX_D1L  = 4;
    localparam int IX_D1H  = 5;
    localparam int IX_DPS  = 14;
    localparam int IX_PAGE = 28;
    localparam int IX_BAUD = 32;
    localparam int IX_PSW  = 31;
    localparam int IX_ACC  = 33;

    // Byte-wide register store
    byte_t regs_ff [N];

    // Bit-addressable locations sit at multiples of eight
    function automatic logic bit_capable(input logic [7:0] a);
        return a[2:0] == 3'h0;
    endfunction

    function automatic logic odd_parity(input logic [7:0] v);
        return ^v;
    endfunction

    logic       direct_ok;
    logic       byte_wr;
    logic       bit_wr;
    logic [N-1:0] sel;
    logic       any_hit;
    byte_t      cur;

    // Decode; indirect accesses never reach this space
    always_comb
    begin
        direct_ok = (req.kind != sfr_bank_pkg::ACC_NONE) && !indirect && req.addr[7];
        byte_wr   = direct_ok && req.write && (req.kind == sfr_bank_pkg::ACC_BYTE);
        bit_wr    = direct_ok && req.write && (req.kind == sfr_bank_pkg::ACC_BIT)
                    && bit_capable(req.addr);
        any_hit   = 1'b0;
        cur       = 8'h00;
        for (int i = 0; i < N; i++)
        begin
            sel[i] = direct_ok && (req.addr == OFFS[i]);
            if (sel[i])
            begin
                any_hit = 1'b1;
                cur     = regs_ff[i];
            end
        end
    end

    // Next value of each register for a core write
    function automatic byte_t write_value(input byte_t old, input sfr_bank_pkg::sfr_req_s r,
                                          input logic bw);
        byte_t v;
        v = old;
        if (bw)
            v[r.bit_sel] = r.wdata[0];
        else
            v = r.wdata;
        return v;
    endfunction

    // Generic registers; special ones handled below
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < N; i++)
                regs_ff[i] <= RSTS[i];
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (sel[i] && (byte_wr || bit_wr))
                    regs_ff[i] <= write_value(regs_ff[i], req, bit_wr);
            end
            if (stack_push && !(sel[IX_SP] && (byte_wr || bit_wr)))
                regs_ff[IX_SP] <= regs_ff[IX_SP] + 8'h01;
            if (acc_we && !(sel[IX_ACC] && (byte_wr || bit_wr)))
                regs_ff[IX_ACC] <= acc_wdata;
            if (!(sel[IX_PSW] && (byte_wr || bit_wr)))
            begin
                if (flag_upd.carry_we)
                    regs_ff[IX_PSW][sfr_bank_pkg::PSW_CARRY] <= flag_upd.carry;
                if (flag_upd.aux_we)
                    regs_ff[IX_PSW][sfr_bank_pkg::PSW_AUX] <= flag_upd.aux;
                if (flag_upd.ovf_we)
                    regs_ff[IX_PSW][sfr_bank_pkg::PSW_OVF] <= flag_upd.ovf;
            end
        end
    end

    logic  parity_now;
    byte_t psw_view;
    byte_t read_view;

    // Parity follows the accumulator, never stored
    always_comb
    begin
        parity_now = odd_parity(regs_ff[IX_ACC]);
        psw_view   = regs_ff[IX_PSW];
        psw_view[sfr_bank_pkg::PSW_PARITY] = parity_now;
        read_view  = cur;
        if (sel[IX_PSW])
            read_view = psw_view;
        if (sel[IX_BAUD])
            read_view = cur & sfr_bank_pkg::BAUD_CTRL_MASK;
    end

    // Read port; unmapped reads give zero
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= 8'h00;
            rbit_ff  <= 1'b0;
            hit_ff   <= 1'b0;
        end
        else
        begin
            rdata_ff <= any_hit ? read_view : 8'h00;
            rbit_ff  <= (any_hit && bit_capable(req.addr)) ? read_view[req.bit_sel] : 1'b0;
            hit_ff   <= any_hit;
        end
    end

    // Derived views for the core
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bank_base_ff           <= 5'h00;
            data_pointer_ff        <= 16'h0000;
            paged_address_high_ff  <= 8'h00;
            stack_pointer_ff       <= sfr_bank_pkg::RST_SP;
            accumulator_ff         <= 8'h00;
            program_status_word_ff <= 8'h00;
        end
        else
        begin
            bank_base_ff <= {regs_ff[IX_PSW][sfr_bank_pkg::PSW_BANK_H],
                             regs_ff[IX_PSW][sfr_bank_pkg::PSW_BANK_L], 3'h0};
            data_pointer_ff <= regs_ff[IX_DPS][0]
                ? {regs_ff[IX_D1H], regs_ff[IX_D1L]}
                : {regs_ff[IX_D0H], regs_ff[IX_D0L]};
            paged_address_high_ff  <= regs_ff[IX_PAGE];
            stack_pointer_ff       <= regs_ff[IX_SP];
            accumulator_ff         <= regs_ff[IX_ACC];
            program_status_word_ff <= psw_view;
        end
    end

    AST_PARITY: assert property (@(posedge clock) disable iff (rst)
        program_status_word_ff[0] == ^$past(regs_ff[IX_ACC]))
        else $error("parity flag wrong");

    AST_BANK: assert property (@(posedge clock) disable iff (rst)
        bank_base_ff == {$past(regs_ff[IX_PSW][4:3]), 3'h0})
        else $error("bank base wrong");

    AST_UNMAPPED: assert property (@(posedge clock) disable iff (rst)
        (direct_ok && !any_hit) |=> (rdata_ff == 8'h00 && !hit_ff))
        else $error("unmapped read not zero");

    AST_INDIRECT: assert property (@(posedge clock) disable iff (rst)
        indirect |=> !hit_ff)
        else $error("indirect access reached register space");

    AST_BITWRITE: assert property (@(posedge clock) disable iff (rst)
        (bit_wr && sel[IX_ACC] && !acc_we) |=>
        ((regs_ff[IX_ACC] ^ $past(regs_ff[IX_ACC])) & ~(8'h01 << $past(req.bit_sel))) == 8'h00)
        else $error("bit write touched other bits");

    AST_BYTEONLY: assert property (@(posedge clock) disable iff (rst)
        (direct_ok && req.write && req.kind == sfr_bank_pkg::ACC_BIT && sel[IX_DPS]) |=>
        $stable(regs_ff[IX_DPS]))
        else $error("bit write to byte-only location");

    AST_PUSH: assert property (@(posedge clock) disable iff (rst)
        (stack_push && !sel[IX_SP]) |=> regs_ff[IX_SP] == $past(regs_ff[IX_SP]) + 8'h01)
        else $error("stack pointer not incremented");

    AST_POINTER: assert property (@(posedge clock) disable iff (rst)
        (byte_wr && sel[IX_DPS]) |=> ($stable(regs_ff[IX_D0L]) && $stable(regs_ff[IX_D1L])
        ##1 data_pointer_ff[7:0] == (regs_ff[IX_DPS][0] ? regs_ff[IX_D1L] : regs_ff[IX_D0L])))
        else $error("pointer select misbehaves");

    AST_BAUD: assert property (@(posedge clock) disable iff (rst)
        sel[IX_BAUD] |=> rdata_ff[6:0] == 7'h00)
        else $error("baud control unused bits read nonzero");

    AST_HIT: assert property (@(posedge clock) disable iff (rst)
        any_hit |=> hit_ff)
        else $error("hit flag missing for implemented register");

    AST_READBACK: assert property (@(posedge clock) disable iff (rst)
        (any_hit && !sel[IX_PSW] && !sel[IX_BAUD]) |=> rdata_ff == $past(cur))
        else $error("read data differs from register");

    AST_PSW_READ: assert property (@(posedge clock) disable iff (rst)
        sel[IX_PSW] |=> rdata_ff == $past(psw_view))
        else $error("status word read wrong");

    AST_IDLE: assert property (@(posedge clock) disable iff (rst)
        (req.kind == sfr_bank_pkg::ACC_NONE) |=> (rdata_ff == 8'h00 && !hit_ff && !rbit_ff))
        else $error("read port not quiet when idle");

    AST_BYTE_LOAD: assert property (@(posedge clock) disable iff (rst)
        (byte_wr && sel[IX_ACC]) |=> regs_ff[IX_ACC] == $past(req.wdata))
        else $error("byte write not stored");

    AST_ACC_LOAD: assert property (@(posedge clock) disable iff (rst)
        (acc_we && !(sel[IX_ACC] && (byte_wr || bit_wr))) |=>
        regs_ff[IX_ACC] == $past(acc_wdata))
        else $error("accumulator load lost");

    AST_ACC_VIEW: assert property (@(posedge clock) disable iff (rst)
        accumulator_ff == $past(regs_ff[IX_ACC]))
        else $error("accumulator copy wrong");

    AST_SP_VIEW: assert property (@(posedge clock) disable iff (rst)
        stack_pointer_ff == $past(regs_ff[IX_SP]))
        else $error("stack pointer copy wrong");

    AST_PAGED: assert property (@(posedge clock) disable iff (rst)
        paged_address_high_ff == $past(regs_ff[IX_PAGE]))
        else $error("paged address copy wrong");

    AST_CARRY: assert property (@(posedge clock) disable iff (rst)
        (flag_upd.carry_we && !(sel[IX_PSW] && (byte_wr || bit_wr))) |=>
        regs_ff[IX_PSW][sfr_bank_pkg::PSW_CARRY] == $past(flag_upd.carry))
        else $error("carry flag update lost");

    AST_AUX: assert property (@(posedge clock) disable iff (rst)
        (flag_upd.aux_we && !(sel[IX_PSW] && (byte_wr || bit_wr))) |=>
        regs_ff[IX_PSW][sfr_bank_pkg::PSW_AUX] == $past(flag_upd.aux))
        else $error("aux carry flag update lost");

    AST_OVF: assert property (@(posedge clock) disable iff (rst)
        (flag_upd.ovf_we && !(sel[IX_PSW] && (byte_wr || bit_wr))) |=>
        regs_ff[IX_PSW][sfr_bank_pkg::PSW_OVF] == $past(flag_upd.ovf))
        else $error("overflow flag update lost");

    AST_BITREAD: assert property (@(posedge clock) disable iff (rst)
        (direct_ok && !bit_capable(req.addr)) |=> !rbit_ff)
        else $error("bit read of byte-only location nonzero");

    AST_INDIRECT_HOLD: assert property (@(posedge clock) disable iff (rst)
        (indirect && !acc_we) |=> $stable(regs_ff[IX_ACC]))
        else $error("indirect access changed a register");

endmodule

/* tb/core_model.sv */
// Core stand-in that drives the direct-address port and side strobes
`timescale 1ns/1ps
module core_model
(
    input  wire logic               clock,
    output sfr_bank_pkg::sfr_req_s  req,
    output logic                    indirect,
    output sfr_bank_pkg::flag_upd_s flag_upd,
    output logic                    stack_push,
    output logic                    acc_we,
    output logic [7:0]              acc_wdata
);
    initial
    begin
        req        = '0;
        indirect   = 1'b0;
        flag_upd   = '0;
        stack_push = 1'b0;
        acc_we     = 1'b0;
        acc_wdata  = 8'h00;
    end

    // One request per edge; back to back calls give one per cycle
    task automatic access(input sfr_bank_pkg::access_e kind, input logic wr,
                          input logic [7:0] addr, input logic [2:0] sel,
                          input logic [7:0] wd, input logic ind);
        @(posedge clock);
        req      <= '{kind, wr, addr, sel, wd};
        indirect <= ind;
    endtask

    // ALU side strobes from the next edge, held until idle or the next side call
    task automatic side(input logic [5:0] f, input logic push, input logic awe,
                        input logic [7:0] ad);
        @(posedge clock);
        flag_upd   <= f;
        stack_push <= push;
        acc_we     <= awe;
        acc_wdata  <= ad;
    endtask

    // Back to idle
    task automatic idle();
        @(posedge clock);
        req        <= '0;
        indirect   <= 1'b0;
        flag_upd   <= '0;
        stack_push <= 1'b0;
        acc_we     <= 1'b0;
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the special register space
`timescale 1ns/1ps
module tb_top;
    logic                    clock;
    logic                    rst;
    sfr_bank_pkg::sfr_req_s  req;
    logic                    indirect;
    sfr_bank_pkg::flag_upd_s flag_upd;
    logic                    stack_push;
    logic                    acc_we;
    logic [7:0]              acc_wdata;
    logic [7:0]              rdata_ff;
    logic                    rbit_ff;
    logic                    hit_ff;
    logic [4:0]              bank_base_ff;
    logic [15:0]             data_pointer_ff;
    logic [7:0]              paged_address_high_ff;
    logic [7:0]              stack_pointer_ff;
    logic [7:0]              accumulator_ff;
    logic [7:0]              program_status_word_ff;
    int                      fails;
    int                      checks;
    int                      seed;
    logic [10:0]             expq[$];
    logic [10:0]             e;
    logic                    pend;
    logic [7:0]              sh [256];
    logic [7:0]              d;
    localparam logic [7:0]   REGS [35] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87,
        8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h92, 8'h98, 8'h99, 8'h9A, 8'h9B,
        8'h9C, 8'h9D, 8'hA8, 8'hA9, 8'hAA, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBF, 8'hC0, 8'hC8,
        8'hD0, 8'hD8, 8'hE0, 8'hF0};

    core_model core (.clock(clock), .req(req), .indirect(indirect), .flag_upd(flag_upd),
        .stack_push(stack_push), .acc_we(acc_we), .acc_wdata(acc_wdata));

    special_register_space dut (.clock(clock), .rst(rst), .req(req), .indirect(indirect),
        .flag_upd(flag_upd), .stack_push(stack_push), .acc_we(acc_we),
        .acc_wdata(acc_wdata), .rdata_ff(rdata_ff), .rbit_ff(rbit_ff), .hit_ff(hit_ff),
        .bank_base_ff(bank_base_ff), .data_pointer_ff(data_pointer_ff),
        .paged_address_high_ff(paged_address_high_ff), .stack_pointer_ff(stack_pointer_ff),
        .accumulator_ff(accumulator_ff), .program_status_word_ff(program_status_word_ff));

    always #2 clock = ~clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (checks > 0 && fails == 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [7:0] rstval(input logic [7:0] a);
        case (a)
            sfr_bank_pkg::OFF_PORT0:     return sfr_bank_pkg::RST_PORT0;
            sfr_bank_pkg::OFF_SP:        return sfr_bank_pkg::RST_SP;
            sfr_bank_pkg::OFF_STRETCH:   return sfr_bank_pkg::RST_STRETCH;
            sfr_bank_pkg::OFF_SER0_RELL: return sfr_bank_pkg::RST_SER0_RELL;
            sfr_bank_pkg::OFF_SER0_RELH: return sfr_bank_pkg::RST_RELH;
            sfr_bank_pkg::OFF_SER1_RELH: return sfr_bank_pkg::RST_RELH;
            default:                     return sfr_bank_pkg::RST_ZERO;
        endcase
    endfunction

    function automatic logic [7:0] rbk(input logic [7:0] a, input logic [7:0] v);
        if (a == sfr_bank_pkg::OFF_BAUD_CTRL)
            return v & sfr_bank_pkg::BAUD_CTRL_MASK;
        if (a == sfr_bank_pkg::OFF_PSW)
            return {v[7:1], ^sh[sfr_bank_pkg::OFF_ACC]};
        return v;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        core.access(sfr_bank_pkg::ACC_BYTE, 1'b1, a, 3'h0, v, 1'b0);
    endtask

    // Note: bit 10 set means only the addressed bit is compared
    task automatic rd(input logic [7:0] a, input logic h, input logic [7:0] v, input logic ind);
        expq.push_back({1'b0, h, 1'b0, v});
        core.access(sfr_bank_pkg::ACC_BYTE, 1'b0, a, 3'h0, 8'h00, ind);
    endtask

    task automatic rdbit(input logic [7:0] a, input logic [2:0] s, input logic b);
        expq.push_back({2'b10, b, 8'h00});
        core.access(sfr_bank_pkg::ACC_BIT, 1'b0, a, s, 8'h00, 1'b0);
    endtask

    task automatic settle();
        core.idle();
        repeat (2) @(negedge clock);
    endtask

    // Result monitor: one cycle after each read request
    always @(negedge clock)
    begin
        if (pend)
        begin
            e = expq.pop_front();
            if (e[10])
                chk({15'h0, rbit_ff}, {15'h0, e[8]});
            else
                chk({7'h0, hit_ff, rdata_ff}, {7'h0, e[9], e[7:0]});
        end
        pend = (req.kind != sfr_bank_pkg::ACC_NONE) && !req.write;
    end

    initial
    begin
        #20000;
        fails++;
        give_verdict();
    end

    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        pend = 1'b0;
        fails = 0;
        checks = 0;
        seed = 82;
        foreach (REGS[i]) sh[REGS[i]] = rstval(REGS[i]);
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (REGS[i]) rd(REGS[i], 1'b1, rstval(REGS[i]), 1'b0);
        foreach (REGS[i])
        begin
            d = 8'($random(seed));
            wr(REGS[i], d);
            rd(REGS[i], 1'b1, rbk(REGS[i], d), 1'b0);
            sh[REGS[i]] = d;
        end
        wr(8'h86, 8'h5A);
        rd(8'h86, 1'b0, 8'h00, 1'b0);
        core.access(sfr_bank_pkg::ACC_BYTE, 1'b1, 8'hE0, 3'h0, ~sh[8'hE0], 1'b1);
        rd(8'hE0, 1'b0, 8'h00, 1'b1);
        rd(8'hE0, 1'b1, sh[8'hE0], 1'b0);
        core.access(sfr_bank_pkg::ACC_BIT, 1'b1, 8'hC0, 3'h5, {7'h0, ~sh[8'hC0][5]}, 1'b0);
        sh[8'hC0][5] = ~sh[8'hC0][5];
        rd(8'hC0, 1'b1, sh[8'hC0], 1'b0);
        core.access(sfr_bank_pkg::ACC_BIT, 1'b1, 8'h81, 3'h0, {7'h0, ~sh[8'h81][0]}, 1'b0);
        rd(8'h81, 1'b1, sh[8'h81], 1'b0);
        core.access(sfr_bank_pkg::ACC_BIT, 1'b1, 8'h92, 3'h0, {7'h0, ~sh[8'h92][0]}, 1'b0);
        rd(8'h92, 1'b1, sh[8'h92], 1'b0);
        core.access(sfr_bank_pkg::ACC_BIT, 1'b1, 8'hE0, 3'h3, {7'h0, ~sh[8'hE0][3]}, 1'b0);
        sh[8'hE0][3] = ~sh[8'hE0][3];
        for (int j = 0; j < 8; j++) rdbit(8'hE0, j[2:0], sh[8'hE0][j]);
        rdbit(8'h81, 3'h0, 1'b0);
        for (int j = 0; j < 4; j++)
        begin
            wr(8'hD0, {3'h0, j[1:0], 3'h0});
            settle();
            chk({11'h0, bank_base_ff}, {11'h0, j[1:0], 3'h0});
        end
        wr(8'h83, 8'h12);
        wr(8'h82, 8'h34);
        wr(8'h85, 8'hAB);
        wr(8'h84, 8'hCD);
        for (int j = 1; j >= 0; j--)
        begin
            wr(8'h92, {7'h0, j[0]});
            settle();
            chk(data_pointer_ff, j[0] ? 16'hABCD : 16'h1234);
        end
        d = 8'($random(seed));
        wr(8'hBF, d);
        settle();
        chk({8'h0, paged_address_high_ff}, {8'h0, d});
        d = 8'($random(seed));
        core.side(6'h3F, 1'b0, 1'b1, d);
        settle();
        chk({8'h0, accumulator_ff}, {8'h0, d});
        chk({8'h0, program_status_word_ff}, {8'h0, 5'b11011, 2'b10, ^d});
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk({stack_pointer_ff, accumulator_ff}, {sfr_bank_pkg::RST_SP, 8'h00});
        chk({program_status_word_ff, 8'h00}, 16'h0000);
        chk(data_pointer_ff, 16'h0000);
        core.side(6'h00, 1'b1, 1'b0, 8'h00);
        settle();
        chk({8'h0, stack_pointer_ff}, 16'h0008);
        give_verdict();
    end
endmodule
